// >>> rtl/pcda_item_fmt.sv
`timescale 1ns/1ns
`include "pcda_params.svh"

// Picks the 32-bit item at a walk position from the snapshot
module pcda_item_fmt
   import pcda_pkg::*;
#(
   parameter int NUM_EV    = 4,
   parameter int NUM_LAT   = 2,
   parameter int CNT_WIDTH = 64
) (
   input  pcda_pos_t                     pos_i,
   input  wire logic [NUM_EV-1:0][63:0]  ev_snap_i,
   input  pcda_lat_t [NUM_LAT-1:0]       lat_snap_i,
   output logic [31:0]                   item_o
);

   // Upper item of a wide value: zero padded at 48, plain at 64
   function automatic logic [31:0] hi_item(input logic [63:0] v);
      if (CNT_WIDTH == 48) begin
         hi_item = {`PCDA_HI16_PAD, v[47:32]};
      end else begin
         hi_item = v[63:32];
      end
   endfunction

   logic [63:0] ev_v;
   pcda_lat_t   lat_v;

   // Item selection per width
   always_comb begin
      ev_v   = ev_snap_i[pos_i.idx[$clog2(NUM_EV+1)-1:0] % NUM_EV];
      lat_v  = lat_snap_i[pos_i.idx[$clog2(NUM_LAT+1)-1:0] % NUM_LAT];
      item_o = `PCDA_UNDEF_READ;
      if (!pos_i.valid) begin
         item_o = `PCDA_UNDEF_READ;                               // Past the last counter
      end else if (!pos_i.is_lat) begin
         if (CNT_WIDTH == 32) begin
            item_o = ev_v[31:0];                                  // RQ4
         end else if (pos_i.item == 3'h0) begin
            item_o = hi_item(ev_v);                               // RQ6 RQ8
         end else begin
            item_o = ev_v[31:0];                                  // RQ6 RQ8
         end
      end else if (CNT_WIDTH == 32) begin
         case (pos_i.item)                                        // RQ5
            3'h0: item_o = lat_v.cnt;
            3'h1: item_o = lat_v.sum[31:0];
            3'h2: item_o = lat_v.sq[31:0];
            3'h3: item_o = {lat_v.lmin[15:0], lat_v.lmax[15:0]};
            default: item_o = `PCDA_UNDEF_READ;
         endcase
      end else begin
         case (pos_i.item)                                        // RQ7 RQ9
            3'h0: item_o = lat_v.cnt;
            3'h1: item_o = hi_item(lat_v.sum);
            3'h2: item_o = lat_v.sum[31:0];
            3'h3: item_o = hi_item(lat_v.sq);
            3'h4: item_o = lat_v.sq[31:0];
            3'h5: item_o = lat_v.lmin;
            3'h6: item_o = lat_v.lmax;
            default: item_o = `PCDA_UNDEF_READ;
         endcase
      end
   end

endmodule // pcda_item_fmt

// >>> rtl/pcda_item_seq.sv
`timescale 1ns/1ns
`include "pcda_params.svh"

// Walks event counters first, then latency counters, item by item
module pcda_item_seq
   import pcda_pkg::*;
#(
   parameter int NUM_EV    = 4,
   parameter int NUM_LAT   = 2,
   parameter int CNT_WIDTH = 64
) (
   input  wire logic      sys_clk_i,
   input  wire logic      rst_i,
   input  wire logic      restart_i,
   input  wire logic      advance_i,
   output pcda_pos_t      pos_o
);

   pcda_seq_t  state_r, state_nxt;
   logic [3:0] idx_r, idx_nxt;
   logic [2:0] item_r, item_nxt;
   logic [2:0] last_ev;
   logic [2:0] last_lat;

   // Last item index per counter kind depends on width
   assign last_ev  = (CNT_WIDTH == 32) ? `PCDA_LAST_EV_ITEM_32 : `PCDA_LAST_EV_ITEM_WD;
   assign last_lat = (CNT_WIDTH == 32) ? `PCDA_LAST_LAT_ITEM_32 : `PCDA_LAST_LAT_ITEM_WD;

   // Next position; restart wins over advance
   always_comb begin
      state_nxt = state_r;
      idx_nxt   = idx_r;
      item_nxt  = item_r;
      if (restart_i) begin                                        // RQ14
         state_nxt = SEQ_EVT;
         idx_nxt   = 4'h0;
         item_nxt  = 3'h0;
      end else if (advance_i) begin
         case (state_r)
            SEQ_EVT: begin                                        // RQ12
               if (item_r == last_ev) begin
                  item_nxt = 3'h0;
                  if (idx_r == 4'(NUM_EV - 1)) begin
                     state_nxt = SEQ_LAT;
                     idx_nxt   = 4'h0;
                  end else begin
                     idx_nxt = idx_r + 4'h1;
                  end
               end else begin
                  item_nxt = item_r + 3'h1;
               end
            end
            SEQ_LAT: begin
               if (item_r == last_lat) begin
                  item_nxt = 3'h0;
                  if (idx_r == 4'(NUM_LAT - 1)) begin
                     state_nxt = SEQ_END;
                     idx_nxt   = 4'h0;
                  end else begin
                     idx_nxt = idx_r + 4'h1;
                  end
               end else begin
                  item_nxt = item_r + 3'h1;
               end
            end
            SEQ_END: begin
               state_nxt = SEQ_END;                               // Walk parks until restart
            end
            default: begin
               state_nxt = SEQ_EVT;
               idx_nxt   = 4'h0;
               item_nxt  = 3'h0;
            end
         endcase
      end
   end

   // Position registers
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= SEQ_EVT;
         idx_r   <= 4'h0;
         item_r  <= 3'h0;
      end else begin
         state_r <= state_nxt;
         idx_r   <= idx_nxt;
         item_r  <= item_nxt;
      end
   end

   // Current position out
   assign pos_o.valid  = (state_r != SEQ_END);
   assign pos_o.is_lat = (state_r == SEQ_LAT);
   assign pos_o.idx    = idx_r;
   assign pos_o.item   = item_r;

endmodule // pcda_item_seq

// >>> rtl/pcda_params.svh
`ifndef PCDA_PARAMS_SVH
`define PCDA_PARAMS_SVH

// ****************************************************************
// Debug register selects
// ****************************************************************
`define PCDA_SEL_VALUE_READ   8'h56
`define PCDA_SEL_VALUE_WRITE  8'h57

// ****************************************************************
// Reset values and undefined read data
// ****************************************************************
`define PCDA_RDATA_RESET      32'h0000_0000
`define PCDA_SNAP_RESET       64'h0000_0000_0000_0000
`define PCDA_UNDEF_READ       32'h0000_0000

// ****************************************************************
// Item counts and layout, per counter width
// ****************************************************************
`define PCDA_LAST_EV_ITEM_32  3'h0
`define PCDA_LAST_EV_ITEM_WD  3'h1
`define PCDA_LAST_LAT_ITEM_32 3'h3
`define PCDA_LAST_LAT_ITEM_WD 3'h6
`define PCDA_HI16_PAD         16'h0000

`endif

// >>> rtl/pcda_pkg.sv
package pcda_pkg;

   // ****************************************************************
   // Item walk state, one-hot
   // ****************************************************************
   typedef enum logic [2:0] {
      SEQ_EVT = 3'b001,
      SEQ_LAT = 3'b010,
      SEQ_END = 3'b100
   } pcda_seq_t;

   // ****************************************************************
   // One latency counter's full value set
   // ****************************************************************
   typedef struct packed {
      logic [31:0] cnt;
      logic [63:0] sum;
      logic [63:0] sq;
      logic [31:0] lmin;
      logic [31:0] lmax;
   } pcda_lat_t;

   // Position of the next item in the walk
   typedef struct packed {
      logic       valid;
      logic       is_lat;
      logic [3:0] idx;
      logic [2:0] item;
   } pcda_pos_t;

   // Preload item handed to the counting logic
   typedef struct packed {
      logic        valid;
      logic        is_lat;
      logic [3:0]  idx;
      logic [2:0]  item;
      logic [31:0] data;
   } pcda_load_t;

endpackage

// >>> rtl/pcda_top.sv
`timescale 1ns/1ns
`include "pcda_params.svh"

// ****************************************************************
// Counter value data access over the debug register channel
// ****************************************************************

// Behaviour
// (RQ1) Value reads return the last sampled snapshot, never live counters.
// (RQ2) Writes to the value read register are ignored, no state change.
// (RQ3) Each value read returns the next item; debugger reads repeatedly.
// (RQ4) Width 32: event counter gives one item, its count.
// (RQ5) Width 32: latency gives count, sum, squared sum, packed min and max.
// (RQ6) Width 48: event gives zero-padded upper 16 bits, then lower 32.
// (RQ7) Width 48: latency gives count, padded sum pair, squared pair, min, max.
// (RQ8) Width 64: event gives upper 32 bits then lower 32 bits.
// (RQ9) Width 64: latency gives count, sum pair, squared pair, min, max.
// (RQ10) Value write register reads back undefined with no side effect.
// (RQ11) Successive value writes preload items in the same order and layout.
// (RQ12) Walk covers all event counters first, then all latency counters.
// (RQ13) Sample captures every counter value in the same cycle.
// (RQ14) Sample or reset command restarts both read and write walks.
module pcda_top
   import pcda_pkg::*;
#(
   parameter int NUM_EV    = 4,
   parameter int NUM_LAT   = 2,
   parameter int CNT_WIDTH = 64
) (
   input  wire logic                     sys_clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     dbg_rd_i,
   input  wire logic                     dbg_wr_i,
   input  wire logic [7:0]               dbg_sel_i,
   input  wire logic [31:0]              dbg_wdata_i,
   input  wire logic                     sample_i,
   input  wire logic                     cmd_reset_i,
   input  wire logic [NUM_EV-1:0][63:0]  ev_live_i,
   input  pcda_lat_t [NUM_LAT-1:0]       lat_live_i,
   output logic [31:0]                   dbg_rdata_o,
   output logic                          dbg_rvalid_o,
   output pcda_load_t                    load_o
);

   // ****************************************************************
   // Access decode
   // ****************************************************************

   logic        restart;
   logic        rd_value;
   logic        rd_wonly;
   logic        wr_value;
   pcda_pos_t   rd_pos;
   pcda_pos_t   wr_pos;
   logic [31:0] rd_item;

   // Sample and reset commands restart the walks and suppress stepping
   assign restart  = sample_i | cmd_reset_i;                      // RQ14
   assign rd_value = dbg_rd_i && (dbg_sel_i == `PCDA_SEL_VALUE_READ);  // RQ3
   assign rd_wonly = dbg_rd_i && (dbg_sel_i == `PCDA_SEL_VALUE_WRITE); // RQ10
   // A write aimed at the read register matches nothing here
   assign wr_value = dbg_wr_i && (dbg_sel_i == `PCDA_SEL_VALUE_WRITE); // RQ2 RQ11

   // ****************************************************************
   // Snapshot storage
   // ****************************************************************

   logic [NUM_EV-1:0][63:0] ev_snap_r, ev_snap_nxt;
   pcda_lat_t [NUM_LAT-1:0] lat_snap_r, lat_snap_nxt;

   // All counters caught on one edge so the set is consistent
   always_comb begin
      ev_snap_nxt  = ev_snap_r;
      lat_snap_nxt = lat_snap_r;
      if (sample_i) begin
         ev_snap_nxt  = ev_live_i;                                // RQ13
         lat_snap_nxt = lat_live_i;                               // RQ13
      end
   end

   // Snapshot registers, one bank per counter
   generate
      for (genvar e = 0; e < NUM_EV; e++) begin : g_ev
         always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
               ev_snap_r[e] <= `PCDA_SNAP_RESET;
            end else begin
               ev_snap_r[e] <= ev_snap_nxt[e];
            end
         end
      end
      for (genvar l = 0; l < NUM_LAT; l++) begin : g_lat
         always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
               lat_snap_r[l] <= '0;
            end else begin
               lat_snap_r[l] <= lat_snap_nxt[l];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Read and write walks
   // ****************************************************************

   // Read walk steps only on a value read outside a restart
   pcda_item_seq #(
      .NUM_EV    (NUM_EV),
      .NUM_LAT   (NUM_LAT),
      .CNT_WIDTH (CNT_WIDTH)
   ) u_rd_seq (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .restart_i (restart),
      .advance_i (rd_value && !restart),                          // RQ3
      .pos_o     (rd_pos)
   );

   // Write walk is independent so reads and preloads do not disturb each other
   pcda_item_seq #(
      .NUM_EV    (NUM_EV),
      .NUM_LAT   (NUM_LAT),
      .CNT_WIDTH (CNT_WIDTH)
   ) u_wr_seq (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .restart_i (restart),
      .advance_i (wr_value && !restart),                          // RQ11
      .pos_o     (wr_pos)
   );

   // Item layout taken from the snapshot, not the live inputs
   pcda_item_fmt #(
      .NUM_EV    (NUM_EV),
      .NUM_LAT   (NUM_LAT),
      .CNT_WIDTH (CNT_WIDTH)
   ) u_fmt (
      .pos_i      (rd_pos),
      .ev_snap_i  (ev_snap_r),                                    // RQ1
      .lat_snap_i (lat_snap_r),                                   // RQ1
      .item_o     (rd_item)
   );

   // ****************************************************************
   // Read answer
   // ****************************************************************

   logic [31:0] rdata_r, rdata_nxt;
   logic        rvalid_r, rvalid_nxt;

   // One-cycle answer; a read racing a restart sees the old position
   always_comb begin
      rdata_nxt  = rdata_r;
      rvalid_nxt = 1'b0;
      if (rd_value) begin
         rdata_nxt  = rd_item;                                    // RQ1 RQ3
         rvalid_nxt = 1'b1;
      end else if (rd_wonly) begin
         rdata_nxt  = `PCDA_UNDEF_READ;                           // RQ10
         rvalid_nxt = 1'b1;
      end
   end

   // Read answer registers
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r  <= `PCDA_RDATA_RESET;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // Answer pins come straight from the registers
   assign dbg_rdata_o  = rdata_r;
   assign dbg_rvalid_o = rvalid_r;

   // ****************************************************************
   // Preload hand-off
   // ****************************************************************

   pcda_load_t load_r, load_nxt;

   // Writes past the last item or during a restart are dropped
   always_comb begin
      load_nxt       = load_r;
      load_nxt.valid = 1'b0;
      if (wr_value && !restart && wr_pos.valid) begin
         load_nxt.valid  = 1'b1;                                  // RQ11
         load_nxt.is_lat = wr_pos.is_lat;
         load_nxt.idx    = wr_pos.idx;
         load_nxt.item   = wr_pos.item;
         load_nxt.data   = dbg_wdata_i;
      end
   end

   // Preload register
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         load_r <= '0;
      end else begin
         load_r <= load_nxt;
      end
   end

   // Preload pins come straight from the register
   assign load_o = load_r;

endmodule // pcda_top

// >>> test/pcda_debug_model.sv
`timescale 1ns/1ns

// Debug side issuing one strobe per register access
module pcda_debug_model (
   input  wire logic        sys_clk_i,
   output logic             dbg_rd_o,
   output logic             dbg_wr_o,
   output logic [7:0]       dbg_sel_o,
   output logic [31:0]      dbg_wdata_o
);
   // Idle bus until the first access
   initial begin
      dbg_rd_o    = 1'b0;
      dbg_wr_o    = 1'b0;
      dbg_sel_o   = 8'h00;
      dbg_wdata_o = 32'h0000_0000;
   end

   // Released strobes drop low, select and data invert so a stale select or data never looks valid
   task automatic access(input logic wr, input logic [7:0] sel, input logic [31:0] data);
      @(negedge sys_clk_i);
      dbg_rd_o    = ~wr;
      dbg_wr_o    = wr;
      dbg_sel_o   = sel;
      dbg_wdata_o = data;
      @(negedge sys_clk_i);
      dbg_rd_o    = 1'b0;
      dbg_wr_o    = 1'b0;
      dbg_sel_o   = ~sel;
      dbg_wdata_o = ~data;
   endtask
endmodule // pcda_debug_model

// >>> test/pcda_top_monitor.sv
`timescale 1ns/1ns
`include "pcda_params.svh"

module pcda_top_monitor
   import pcda_pkg::*;
#(
   parameter int NUM_EV    = 4,
   parameter int NUM_LAT   = 2,
   parameter int CNT_WIDTH = 64
) (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        dbg_rd_i,
   input  wire logic        dbg_wr_i,
   input  wire logic [7:0]  dbg_sel_i,
   input  wire logic [31:0] dbg_wdata_i,
   input  wire logic        sample_i,
   input  wire logic        cmd_reset_i,
   input  wire logic [31:0] dbg_rdata_i,
   input  wire logic        dbg_rvalid_i,
   input  pcda_load_t       load_i
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   logic rd_v;
   logic rd_w;
   logic wr_ok;
   logic fresh_r;
   // Access decode with the same selects as the block
   assign rd_v  = dbg_rd_i && dbg_sel_i == `PCDA_SEL_VALUE_READ;
   assign rd_w  = dbg_rd_i && dbg_sel_i == `PCDA_SEL_VALUE_WRITE;
   assign wr_ok = dbg_wr_i && dbg_sel_i == `PCDA_SEL_VALUE_WRITE && !sample_i && !cmd_reset_i;

   // Set by a restart until the first accepted write
   always_ff @(posedge sys_clk_i or posedge rst_i)
      if (rst_i) fresh_r <= 1'b1;
      else if (sample_i || cmd_reset_i) fresh_r <= 1'b1;
      else if (wr_ok) fresh_r <= 1'b0;

   // Read answer timing and data
   chk_read_answer: assert property (rd_v |=> dbg_rvalid_i)
      else $error("value read not answered next cycle");
   chk_no_stray_answer: assert property (!(rd_v || rd_w) |=> !dbg_rvalid_i)
      else $error("answer without a read");
   chk_rdata_hold: assert property (!dbg_rvalid_i |-> $stable(dbg_rdata_i))
      else $error("read data moved without an answer");
   chk_undef_read: assert property (rd_w |=> dbg_rvalid_i && dbg_rdata_i == `PCDA_UNDEF_READ)
      else $error("write register read gave wrong data");
   // Preload hand-off
   chk_ro_write: assert property (dbg_wr_i && dbg_sel_i == `PCDA_SEL_VALUE_READ |=> !load_i.valid)
      else $error("write to read register loaded an item");
   chk_load_cause: assert property (load_i.valid |-> $past(wr_ok) && load_i.data == $past(dbg_wdata_i))
      else $error("load without a matching write");
   chk_cmd_drop: assert property (dbg_wr_i && (sample_i || cmd_reset_i) |=> !load_i.valid)
      else $error("write during restart was loaded");
   chk_restart_first: assert property (wr_ok && fresh_r |=> load_i.valid && !load_i.is_lat
                                       && load_i.idx == 4'h0 && load_i.item == 3'h0)
      else $error("first write after restart not at first item");
endmodule // pcda_top_monitor

bind pcda_top pcda_top_monitor #(.NUM_EV(NUM_EV), .NUM_LAT(NUM_LAT), .CNT_WIDTH(CNT_WIDTH)) u_mon (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .dbg_rd_i(dbg_rd_i), .dbg_wr_i(dbg_wr_i), .dbg_sel_i(dbg_sel_i),
   .dbg_wdata_i(dbg_wdata_i), .sample_i(sample_i), .cmd_reset_i(cmd_reset_i), .dbg_rdata_i(dbg_rdata_o),
   .dbg_rvalid_i(dbg_rvalid_o), .load_i(load_o));

// >>> test/test_perf_counter_data_access.sv
`timescale 1ns/1ns
`include "pcda_params.svh"

module test_perf_counter_data_access;
   import pcda_pkg::*;
   localparam int NE = 2;
   localparam int NL = 1;
   localparam int WD [3] = '{32, 48, 64};
   logic                sys_clk_i;
   logic                rst_i;
   logic                sample_i;
   logic                cmd_reset_i;
   logic                dbg_rd;
   logic                dbg_wr;
   logic [7:0]          dbg_sel;
   logic [31:0]         dbg_wdata;
   logic [NE-1:0][63:0] ev_live;
   logic [NE-1:0][63:0] snap_ev;
   pcda_lat_t [NL-1:0]  lat_live;
   pcda_lat_t [NL-1:0]  snap_lat;
   logic [31:0]         rdata [3];
   logic                rvalid [3];
   pcda_load_t          load [3];
   logic [31:0]         exp_q [3][$];
   logic [7:0]          pos_q [3][$];
   int                  mismatches;
   int                  n_tests;
   int                  cycles;

   pcda_debug_model u_dbg (.sys_clk_i(sys_clk_i), .dbg_rd_o(dbg_rd), .dbg_wr_o(dbg_wr),
                           .dbg_sel_o(dbg_sel), .dbg_wdata_o(dbg_wdata));

   // One instance per counter width, same stimulus for all
   for (genvar g = 0; g < 3; g++) begin : g_w
      pcda_top #(.NUM_EV(NE), .NUM_LAT(NL), .CNT_WIDTH(WD[g])) dut (
         .sys_clk_i(sys_clk_i), .rst_i(rst_i), .dbg_rd_i(dbg_rd), .dbg_wr_i(dbg_wr), .dbg_sel_i(dbg_sel),
         .dbg_wdata_i(dbg_wdata), .sample_i(sample_i), .cmd_reset_i(cmd_reset_i), .ev_live_i(ev_live),
         .lat_live_i(lat_live), .dbg_rdata_o(rdata[g]), .dbg_rvalid_o(rvalid[g]), .load_o(load[g]));
   end

   task automatic complete_run();
      if (mismatches == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] up(int w, logic [63:0] v);
      return (w == 48) ? {16'h0000, v[47:32]} : v[63:32];
   endfunction

   // Expected item list and walk positions from the saved snapshot
   task automatic build();
      for (int g = 0; g < 3; g++) begin
         exp_q[g] = {};
         pos_q[g] = {};
         for (int e = 0; e < NE; e++) begin
            if (WD[g] != 32) begin
               exp_q[g].push_back(up(WD[g], snap_ev[e]));
               pos_q[g].push_back({1'b0, e[3:0], 3'h0});
            end
            exp_q[g].push_back(snap_ev[e][31:0]);
            pos_q[g].push_back({1'b0, e[3:0], (WD[g] == 32) ? 3'h0 : 3'h1});
         end
         for (int l = 0; l < NL; l++) begin
            logic [31:0] it [$];
            pcda_lat_t c;
            c = snap_lat[l];
            if (WD[g] == 32)
               it = '{c.cnt, c.sum[31:0], c.sq[31:0], {c.lmin[15:0], c.lmax[15:0]}};
            else
               it = '{c.cnt, up(WD[g], c.sum), c.sum[31:0], up(WD[g], c.sq), c.sq[31:0], c.lmin, c.lmax};
            foreach (it[k]) begin
               exp_q[g].push_back(it[k]);
               pos_q[g].push_back({1'b1, l[3:0], k[2:0]});
            end
         end
      end
   endtask

   task automatic set_live(input logic [7:0] s);
      for (int e = 0; e < NE; e++)
         ev_live[e] = {24'h12_3456, s, 24'h9A_BCDE, s + 8'(e)};
      for (int l = 0; l < NL; l++)
         lat_live[l] = {24'h0C_0C0C, s, 64'h5A5A_1234_F00D_0000 + s, 64'h3C3C_5678_BEEF_0000 + s + l,
                        32'h0001_0002 + s, 32'h0003_0004 + s};
   endtask

   // Sample or reset command pulse; both restart the walks
   task automatic pulse(input logic smp);
      @(negedge sys_clk_i);
      sample_i    = smp;
      cmd_reset_i = ~smp;
      if (smp) begin
         snap_ev  = ev_live;
         snap_lat = lat_live;
      end
      @(negedge sys_clk_i);
      sample_i    = 1'b0;
      cmd_reset_i = 1'b0;
      build();
   endtask

   // Parked walks, shorter at width 32, answer zero
   task automatic read_next();
      u_dbg.access(1'b0, `PCDA_SEL_VALUE_READ, 32'h0000_0000);
      for (int g = 0; g < 3; g++) begin
         check({31'h0, rvalid[g]}, 32'h0000_0001);
         check(rdata[g], (exp_q[g].size() > 0) ? exp_q[g].pop_front() : 32'h0000_0000);
      end
   endtask

   task automatic write_next(input logic [31:0] d);
      u_dbg.access(1'b1, `PCDA_SEL_VALUE_WRITE, d);
      for (int g = 0; g < 3; g++) begin
         check({31'h0, load[g].valid}, {31'h0, pos_q[g].size() > 0});
         if (pos_q[g].size() > 0) begin
            check({24'h0, load[g].is_lat, load[g].idx, load[g].item}, {24'h0, pos_q[g].pop_front()});
            check(load[g].data, d);
         end
      end
   endtask

   task automatic t_reset();
      for (int g = 0; g < 3; g++) begin
         check(rdata[g], `PCDA_RDATA_RESET);
         check({31'h0, rvalid[g] | load[g].valid}, 32'h0000_0000);
      end
   endtask

   // Whole read walk with stray accesses in the middle; live values move on
   task automatic t_read_walk();
      set_live(8'h10);
      pulse(1'b1);
      set_live(8'h77);
      for (int k = 0; k < 12; k++) begin
         if (k == 3) begin
            u_dbg.access(1'b1, `PCDA_SEL_VALUE_READ, 32'hFFFF_FFFF);
            for (int g = 0; g < 3; g++)
               check({31'h0, load[g].valid}, 32'h0000_0000);
            u_dbg.access(1'b0, `PCDA_SEL_VALUE_WRITE, 32'h0000_0000);
            for (int g = 0; g < 3; g++)
               check(rdata[g], `PCDA_UNDEF_READ);
            u_dbg.access(1'b0, 8'h00, 32'h0000_0000);
            for (int g = 0; g < 3; g++)
               check({31'h0, rvalid[g]}, 32'h0000_0000);
         end
         read_next();
      end
   endtask

   // Write in the restart cycle is dropped, then a full preload walk
   task automatic t_write_walk();
      fork
         pulse(1'b0);
         u_dbg.access(1'b1, `PCDA_SEL_VALUE_WRITE, 32'hDEAD_0000);
      join
      for (int g = 0; g < 3; g++)
         check({31'h0, load[g].valid}, 32'h0000_0000);
      for (int k = 0; k < 12; k++)
         write_next(32'hC0DE_0000 + k);
   endtask

   // Mid-walk restarts go back to the first item
   task automatic t_restart();
      pulse(1'b0);
      read_next();
      read_next();
      set_live(8'h42);
      pulse(1'b1);
      repeat (3) read_next();
      pulse(1'b0);
      read_next();
   endtask

   // Free running clock, 10 ns period
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   // Hang guard, far above the roughly 90 cycles the run needs
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         complete_run();
      end
   end

   // Reset, then the scenarios in order
   initial begin
      rst_i       = 1'b1;
      sample_i    = 1'b0;
      cmd_reset_i = 1'b0;
      set_live(8'h01);
      repeat (10) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      rst_i = 1'b0;
      t_reset();
      t_read_walk();
      t_write_walk();
      t_restart();
      complete_run();
   end
endmodule // test_perf_counter_data_access
